// ===== src/cfg_preload.sv
//Behaviour
//- Mask bit 0 passes, 1 suppresses error drive; event flag still sets
//- Bit 0: master timeout discard
//- Bit 1: delayed read retry discard
//- Bit 2: delayed write retry discard
//- Bit 3: posted write retry discard
//- Bit 4: target abort on posted write
//- Bit 5: master abort on posted write
//- Bit 6: parity error on posted write
//- Bit 7 reads zero; reset zero
//- Mask loaded by preload or processor
//- Preload only when header bits 10b
//- Bad header: stop, keep reset values
//- Read ascending, shift through chain
//- Bytes 04h-11h: class, subsystem, timing
//- Bytes 12h-2Fh: window setup values
//- Bytes 30h-37h: control words, masks
//- Bytes 38h-42h: power management data
//- Setup word loads capability bits
//- Setup word loads csr, enable, self-test
//- Unmasked event pulses error output
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
module cfg_preload (
    input  wire logic                                aclk,          // Bridge clock
    input  wire logic                                aresetn,       // Sync reset
    input  wire logic [preload_pkg::AXI_AW-1:0]      s_awaddr,      // Write address
    input  wire logic                                s_awvalid,     // Write address valid
    output logic                                     s_awready,     // Write address ready
    input  wire logic [preload_pkg::AXI_DW-1:0]      s_wdata,       // Write data
    input  wire logic [3:0]                          s_wstrb,       // Byte enables
    input  wire logic                                s_wvalid,      // Write data valid
    output logic                                     s_wready,      // Write data ready
    output logic [1:0]                               s_bresp,       // Write response
    output logic                                     s_bvalid,      // Write response valid
    input  wire logic                                s_bready,      // Write response ready
    input  wire logic [preload_pkg::AXI_AW-1:0]      s_araddr,      // Read address
    input  wire logic                                s_arvalid,     // Read address valid
    output logic                                     s_arready,     // Read address ready
    output logic [preload_pkg::AXI_DW-1:0]           s_rdata,       // Read data
    output logic [1:0]                               s_rresp,       // Read response
    output logic                                     s_rvalid,      // Read data valid
    input  wire logic                                s_rready,      // Read data ready
    output logic                                     rom_req,       // ROM byte request
    output logic [preload_pkg::ROM_AW-1:0]           rom_addr,      // ROM byte address
    input  wire logic [7:0]                          rom_data,      // ROM byte
    input  wire logic                                rom_ack,       // ROM byte valid
    input  wire logic [preload_pkg::MASK_BITS-1:0]   us_evt,        // Upstream event pulses
    output logic                                     sec_serr_o,    // Error pin level
    output logic                                     sec_serr_oe_n, // Error pin drive, low
    output logic                                     cfg_retry,     // Host config held off
    output preload_pkg::cfg_t                        cfg_out,       // Preloaded fields
    output preload_pkg::pm_t                         pm_out         // Power mgmt fields
);
    logic                              aw_hold_ff, nxt_aw_hold;
    logic [preload_pkg::AXI_AW-1:0]    aw_addr_ff, nxt_aw_addr;
    logic                              w_hold_ff, nxt_w_hold;
    logic [preload_pkg::AXI_DW-1:0]    w_data_ff, nxt_w_data;
    logic [3:0]                        w_strb_ff, nxt_w_strb;
    logic                              awready_ff, nxt_awready;
    logic                              wready_ff, nxt_wready;
    logic                              bvalid_ff, nxt_bvalid;
    logic                              arready_ff, nxt_arready;
    logic                              rvalid_ff, nxt_rvalid;
    logic [preload_pkg::AXI_DW-1:0]    rdata_ff, nxt_rdata;
    logic                              wr_fire;
    logic [preload_pkg::IDX_W-1:0]     wr_idx;
    logic [preload_pkg::IDX_W-1:0]     rd_idx;

    logic [preload_pkg::CFG_BITS-1:0]  chain_ff, nxt_chain;
    preload_pkg::cfg_t                 cfg_ff, nxt_cfg;
    preload_pkg::cfg_t                 chain_view;
    preload_pkg::pm_t                  pm_ff, nxt_pm;
    logic [preload_pkg::MASK_BITS-1:0] mask_ff, nxt_mask;
    logic                              retry_ff, nxt_retry;

    logic                              byte_vld;
    logic [7:0]                        byte_val;
    logic                              commit;
    preload_pkg::load_status_t         ld_status;
    logic [preload_pkg::MASK_BITS-1:0] flags;
    logic                              flag_clr_we;

    rom_loader u_loader (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .rom_req_ff  (rom_req),
        .rom_addr_ff (rom_addr),
        .rom_data    (rom_data),
        .rom_ack     (rom_ack),
        .byte_vld_ff (byte_vld),
        .byte_ff     (byte_val),
        .commit_ff   (commit),
        .status_ff   (ld_status)
    );

    serr_gate u_serr (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .evt          (us_evt),
        .mask         (mask_ff),
        .clr_we       (flag_clr_we),
        .clr_bits     (w_data_ff[preload_pkg::MASK_BITS-1:0]),
        .flags_ff     (flags),
        .serr_o_ff    (sec_serr_o),
        .serr_oe_n_ff (sec_serr_oe_n)
    );

    // Register bus: write path
    assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
    assign wr_idx  = aw_addr_ff[preload_pkg::AXI_AW-1:2];
    assign rd_idx  = s_araddr[preload_pkg::AXI_AW-1:2];
    assign flag_clr_we = wr_fire && w_strb_ff[0] && (wr_idx == preload_pkg::IDX_EVT_STATUS);

    always_comb begin
        nxt_aw_hold = aw_hold_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_hold  = w_hold_ff;
        nxt_w_data  = w_data_ff;
        nxt_w_strb  = w_strb_ff;
        nxt_bvalid  = bvalid_ff;
        if (s_awvalid && awready_ff) begin
            nxt_aw_hold = 1'b1;
            nxt_aw_addr = s_awaddr;
        end
        if (s_wvalid && wready_ff) begin
            nxt_w_hold = 1'b1;
            nxt_w_data = s_wdata;
            nxt_w_strb = s_wstrb;
        end
        if (wr_fire) begin
            nxt_aw_hold = 1'b0;
            nxt_w_hold  = 1'b0;
            nxt_bvalid  = 1'b1;
        end
        if (bvalid_ff && s_bready) begin
            nxt_bvalid = 1'b0;
        end
        nxt_awready = !nxt_aw_hold && !nxt_bvalid;
        nxt_wready  = !nxt_w_hold && !nxt_bvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_hold_ff  <= 1'b0;
            w_data_ff  <= '0;
            w_strb_ff  <= 4'h0;
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
        end else begin
            aw_hold_ff <= nxt_aw_hold;
            aw_addr_ff <= nxt_aw_addr;
            w_hold_ff  <= nxt_w_hold;
            w_data_ff  <= nxt_w_data;
            w_strb_ff  <= nxt_w_strb;
            bvalid_ff  <= nxt_bvalid;
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
        end
    end

    assign s_awready = awready_ff;
    assign s_wready  = wready_ff;
    assign s_bvalid  = bvalid_ff;
    assign s_bresp   = preload_pkg::RESP_OKAY;

    // Register bus: read path, data captured when the address is taken
    always_comb begin
        nxt_arready = arready_ff;
        nxt_rvalid  = rvalid_ff;
        nxt_rdata   = rdata_ff;
        if (s_arvalid && arready_ff) begin
            nxt_arready = 1'b0;
            nxt_rvalid  = 1'b1;
            if (rd_idx == preload_pkg::IDX_SEC_MASK) begin
                nxt_rdata = {{(preload_pkg::AXI_DW-preload_pkg::MASK_BITS){1'b0}}, mask_ff};
            end else if (rd_idx == preload_pkg::IDX_EVT_STATUS) begin
                nxt_rdata = {{(preload_pkg::AXI_DW-preload_pkg::MASK_BITS){1'b0}}, flags};
            end else if (rd_idx == preload_pkg::IDX_PRELOAD) begin
                nxt_rdata = {{(preload_pkg::AXI_DW-$bits(ld_status)){1'b0}}, ld_status};
            end else begin
                nxt_rdata = '0;
            end
        end
        if (rvalid_ff && s_rready) begin
            nxt_rvalid  = 1'b0;
            nxt_arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= '0;
        end else begin
            arready_ff <= (arready_ff || rvalid_ff) ? nxt_arready : 1'b1;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
        end
    end

    assign s_arready = arready_ff;
    assign s_rvalid  = rvalid_ff;
    assign s_rdata   = rdata_ff;
    assign s_rresp   = preload_pkg::RESP_OKAY;

    // Scan chain: bytes enter at the top and move toward bit 0
    assign chain_view = preload_pkg::cfg_t'(chain_ff);

    always_comb begin
        nxt_chain = chain_ff;
        if (byte_vld) begin
            nxt_chain = {byte_val, chain_ff[preload_pkg::CFG_BITS-1:8]};
        end
    end

    // Targets change only at commit (mask also on a register write), so an aborted load leaves reset values
    always_comb begin
        nxt_cfg   = cfg_ff;
        nxt_pm    = pm_ff;
        nxt_mask  = mask_ff;
        nxt_retry = retry_ff;
        if (wr_fire && w_strb_ff[0] && (wr_idx == preload_pkg::IDX_SEC_MASK)) begin
            nxt_mask = w_data_ff[preload_pkg::MASK_BITS-1:0];
        end
        if (commit) begin
            nxt_cfg  = chain_view;
            nxt_mask = chain_view.sec_err_mask[preload_pkg::MASK_BITS-1:0];
            nxt_pm.pm_cap[14:9] = chain_view.pm_bist_word[preload_pkg::PMW_CAP_HI_H:preload_pkg::PMW_CAP_HI_L];
            nxt_pm.pm_cap[5]    = chain_view.pm_bist_word[preload_pkg::PMW_CAP_MID];
            nxt_pm.pm_cap[2:0]  = chain_view.pm_bist_word[preload_pkg::PMW_CAP_LO_H:preload_pkg::PMW_CAP_LO_L];
            nxt_pm.pm_csr[14:13] = chain_view.pm_bist_word[preload_pkg::PMW_CSR_H:preload_pkg::PMW_CSR_L];
            nxt_pm.pm_data_en    = chain_view.pm_bist_word[preload_pkg::PMW_DATA_EN];
            nxt_pm.bist[7]       = chain_view.pm_bist_word[preload_pkg::PMW_BIST];
        end
        if (ld_status.done || ld_status.aborted) begin
            nxt_retry = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chain_ff <= '0;
            cfg_ff   <= preload_pkg::CFG_RESET;
            pm_ff    <= '0;
            mask_ff  <= preload_pkg::MASK_RESET;
            retry_ff <= 1'b1;
        end else begin
            chain_ff <= nxt_chain;
            cfg_ff   <= nxt_cfg;
            pm_ff    <= nxt_pm;
            mask_ff  <= nxt_mask;
            retry_ff <= nxt_retry;
        end
    end

    assign cfg_out   = cfg_ff;
    assign pm_out    = pm_ff;
    assign cfg_retry = retry_ff;
endmodule : cfg_preload

// ===== src/preload_pkg.sv
package preload_pkg;

    // Register bus geometry
    localparam int          AXI_AW        = 12;
    localparam int          AXI_DW        = 32;
    localparam int          IDX_W         = 10;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;

    // Register indices; byte address is index times four
    localparam logic [IDX_W-1:0] IDX_SEC_MASK   = 10'h0d5;
    localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 10'h0d6;
    localparam logic [IDX_W-1:0] IDX_PRELOAD    = 10'h0d7;

    // Error mask layout
    localparam int          MASK_BITS     = 7;
    localparam int          EVT_TIMEOUT   = 0;
    localparam int          EVT_DRD_DROP  = 1;
    localparam int          EVT_DWR_DROP  = 2;
    localparam int          EVT_PW_DROP   = 3;
    localparam int          EVT_TGT_ABORT = 4;
    localparam int          EVT_MST_ABORT = 5;
    localparam int          EVT_PAR_ERR   = 6;
    localparam logic [MASK_BITS-1:0] MASK_RESET = 7'h00;

    // Serial ROM image layout
    localparam int          ROM_AW        = 8;
    localparam logic [ROM_AW-1:0] ROM_HDR_ADDR   = 8'h00;
    localparam logic [ROM_AW-1:0] ROM_FIRST_LOAD = 8'h04;
    localparam logic [ROM_AW-1:0] ROM_LAST_ADDR  = 8'h42;
    localparam logic [1:0]  HDR_ENABLE    = 2'h2;
    localparam int          HDR_HI        = 7;
    localparam int          HDR_LO        = 6;

    // Power management setup word fields
    localparam int          PMW_CAP_HI_H  = 15;
    localparam int          PMW_CAP_HI_L  = 10;
    localparam int          PMW_CAP_MID   = 9;
    localparam int          PMW_CAP_LO_H  = 8;
    localparam int          PMW_CAP_LO_L  = 6;
    localparam int          PMW_CSR_H     = 5;
    localparam int          PMW_CSR_L     = 4;
    localparam int          PMW_DATA_EN   = 3;
    localparam int          PMW_BIST      = 2;

    localparam logic [15:0] ARB_RESET     = 16'h0200;

    typedef enum {ST_HDR, ST_READ, ST_COMMIT, ST_DONE, ST_ABORT} load_state_t;

    // Preloaded fields, last ROM byte first so byte 04h lands at bit 0
    typedef struct packed {
        logic [15:0] pm_bist_word;
        logic [7:0]  rsvd_40;
        logic [63:0] pm_data_vals;
        logic [7:0]  sec_err_mask;
        logic [7:0]  pri_err_mask;
        logic [15:0] arb_ctl;
        logic [15:0] chip_ctl1;
        logic [15:0] chip_ctl0;
        logic [31:0] us_mem1_setup;
        logic [31:0] us_io0_setup;
        logic [15:0] exp_rom_setup;
        logic [31:0] ds_mem3_upper;
        logic [31:0] ds_mem3_setup;
        logic [31:0] ds_mem2_setup;
        logic [31:0] ds_io1_setup;
        logic [31:0] ds_mem0_setup;
        logic [7:0]  sec_max_lat;
        logic [7:0]  sec_min_gnt;
        logic [7:0]  sec_base_class;
        logic [7:0]  sec_sub_class;
        logic [7:0]  sec_prog_if;
        logic [7:0]  pri_max_lat;
        logic [7:0]  pri_min_gnt;
        logic [15:0] subsys_id;
        logic [15:0] subsys_vid;
        logic [7:0]  pri_base_class;
        logic [7:0]  pri_sub_class;
        logic [7:0]  pri_prog_if;
    } cfg_t;

    localparam int   CFG_BITS  = $bits(cfg_t);
    localparam cfg_t CFG_RESET = '{arb_ctl: ARB_RESET, default: '0};

    typedef struct packed {
        logic [15:0] pm_cap;
        logic [15:0] pm_csr;
        logic        pm_data_en;
        logic [7:0]  bist;
    } pm_t;

    typedef struct packed {
        logic busy;
        logic enabled;
        logic aborted;
        logic done;
    } load_status_t;

endpackage : preload_pkg

// ===== src/rom_loader.sv
`timescale 1ns/10ps
module rom_loader (
    input  wire logic                            aclk,         // Bridge clock
    input  wire logic                            aresetn,      // Sync reset
    output logic                                 rom_req_ff,   // Byte request level
    output logic [preload_pkg::ROM_AW-1:0]       rom_addr_ff,  // Byte address
    input  wire logic [7:0]                      rom_data,     // Returned byte
    input  wire logic                            rom_ack,      // Byte valid
    output logic                                 byte_vld_ff,  // Shift strobe
    output logic [7:0]                           byte_ff,      // Byte to shift
    output logic                                 commit_ff,    // Chain complete
    output preload_pkg::load_status_t            status_ff     // Loader state
);
    preload_pkg::load_state_t          state_ff, nxt_state;
    logic                              nxt_rom_req;
    logic [preload_pkg::ROM_AW-1:0]    nxt_rom_addr;
    logic                              nxt_byte_vld;
    logic [7:0]                        nxt_byte;
    logic                              nxt_commit;
    preload_pkg::load_status_t         nxt_status;

    always_comb begin
        nxt_state    = state_ff;
        nxt_rom_req  = rom_req_ff;
        nxt_rom_addr = rom_addr_ff;
        nxt_byte_vld = 1'b0;
        nxt_byte     = byte_ff;
        nxt_commit   = 1'b0;
        case (state_ff)
            preload_pkg::ST_HDR: begin
                nxt_rom_req = 1'b1;
                if (rom_ack) begin
                    if (rom_data[preload_pkg::HDR_HI:preload_pkg::HDR_LO] == preload_pkg::HDR_ENABLE) begin
                        nxt_state    = preload_pkg::ST_READ;
                        nxt_rom_addr = rom_addr_ff + 1'b1;
                    end else begin
                        nxt_state   = preload_pkg::ST_ABORT;
                        nxt_rom_req = 1'b0;
                    end
                end
            end
            preload_pkg::ST_READ: begin
                if (rom_ack) begin
                    // Reserved bytes 01h..03h are read and dropped
                    if (rom_addr_ff >= preload_pkg::ROM_FIRST_LOAD) begin
                        nxt_byte_vld = 1'b1;
                        nxt_byte     = rom_data;
                    end
                    if (rom_addr_ff == preload_pkg::ROM_LAST_ADDR) begin
                        nxt_state   = preload_pkg::ST_COMMIT;
                        nxt_rom_req = 1'b0;
                    end else begin
                        nxt_rom_addr = rom_addr_ff + 1'b1;
                    end
                end
            end
            preload_pkg::ST_COMMIT: begin
                nxt_commit = 1'b1;
                nxt_state  = preload_pkg::ST_DONE;
            end
            default: begin
                nxt_rom_req = 1'b0;
            end
        endcase
        nxt_status.busy    = (nxt_state == preload_pkg::ST_HDR) || (nxt_state == preload_pkg::ST_READ)
                             || (nxt_state == preload_pkg::ST_COMMIT);
        nxt_status.enabled = (nxt_state != preload_pkg::ST_HDR) && (nxt_state != preload_pkg::ST_ABORT);
        nxt_status.aborted = (nxt_state == preload_pkg::ST_ABORT);
        nxt_status.done    = (nxt_state == preload_pkg::ST_DONE);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff    <= preload_pkg::ST_HDR;
            rom_req_ff  <= 1'b0;
            rom_addr_ff <= preload_pkg::ROM_HDR_ADDR;
            byte_vld_ff <= 1'b0;
            byte_ff     <= 8'h00;
            commit_ff   <= 1'b0;
            status_ff   <= '{busy: 1'b1, default: 1'b0};
        end else begin
            state_ff    <= nxt_state;
            rom_req_ff  <= nxt_rom_req;
            rom_addr_ff <= nxt_rom_addr;
            byte_vld_ff <= nxt_byte_vld;
            byte_ff     <= nxt_byte;
            commit_ff   <= nxt_commit;
            status_ff   <= nxt_status;
        end
    end
endmodule : rom_loader

// ===== src/serr_gate.sv
`timescale 1ns/10ps
module serr_gate (
    input  wire logic                              aclk,          // Bridge clock
    input  wire logic                              aresetn,       // Sync reset
    input  wire logic [preload_pkg::MASK_BITS-1:0] evt,           // Event pulses
    input  wire logic [preload_pkg::MASK_BITS-1:0] mask,          // 1 suppresses
    input  wire logic                              clr_we,        // W1C strobe
    input  wire logic [preload_pkg::MASK_BITS-1:0] clr_bits,      // W1C data
    output logic      [preload_pkg::MASK_BITS-1:0] flags_ff,      // Sticky flags
    output logic                                   serr_o_ff,     // Pin level
    output logic                                   serr_oe_n_ff   // Low drives
);
    logic [preload_pkg::MASK_BITS-1:0] nxt_flags;
    logic [preload_pkg::MASK_BITS-1:0] pass;
    logic                              nxt_oe_n;

    genvar g;
    generate
        for (g = 0; g < preload_pkg::MASK_BITS; g++) begin : g_evt
            assign pass[g] = evt[g] && !mask[g];
        end
    endgenerate

    always_comb begin
        // Set wins over a clear in the same cycle
        nxt_flags = (flags_ff & ~(clr_bits & {preload_pkg::MASK_BITS{clr_we}})) | evt;
        nxt_oe_n  = !(|pass);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_ff     <= '0;
            serr_o_ff    <= 1'b0;
            serr_oe_n_ff <= 1'b1;
        end else begin
            flags_ff     <= nxt_flags;
            serr_o_ff    <= 1'b0;
            serr_oe_n_ff <= nxt_oe_n;
        end
    end
endmodule : serr_gate

// ===== tb/cfg_preload_sva.sv
`timescale 1ns/10ps
module preload_chk (
    input wire logic              aclk,          // Clock
    input wire logic              aresetn,       // Reset
    input wire logic              rom_req,       // Byte request
    input wire logic [7:0]        rom_addr,      // Byte address
    input wire logic [7:0]        rom_data,      // Byte
    input wire logic              rom_ack,       // Byte valid
    input wire logic [6:0]        us_evt,        // Events
    input wire logic              sec_serr_o,    // Pin level
    input wire logic              sec_serr_oe_n, // Pin drive
    input wire logic              cfg_retry,     // Hold off
    input wire preload_pkg::cfg_t cfg_out        // Fields
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire take = rom_req && rom_ack;
    wire bad  = take && rom_addr == 8'h00 && rom_data[7:6] != 2'h2;
    pin_low_a: assert property (sec_serr_o == 1'b0) else $error("pin level high");
    drive_cause_a: assert property (!sec_serr_oe_n |-> $past(|us_evt)) else $error("drive no event");
    hdr_stop_a: assert property (bad |=> !rom_req) else $error("read after bad header");
    hdr_keep_a: assert property (bad |=> (cfg_out == preload_pkg::CFG_RESET) [*4]) else $error("cfg changed");
    hdr_start_a: assert property (rom_addr == 8'h01 && $past(rom_addr) == 8'h00 |->
        $past(take && rom_data[7:6] == 2'h2)) else $error("load without header");
    addr_step_a: assert property (take && rom_addr != 8'h00 && rom_addr < 8'h42 |=>
        rom_addr == $past(rom_addr) + 8'h01) else $error("address not ascending");
    last_stop_a: assert property (take && rom_addr == 8'h42 |=> !rom_req) else $error("read past end");
    retry_hold_a: assert property (rom_req |-> cfg_retry) else $error("host not held off");
    cover property (take && rom_addr == 8'h42);
    cover property (bad);
    cover property (!sec_serr_oe_n);
endmodule : preload_chk
bind cfg_preload preload_chk preload_chk_i (.aclk(aclk), .aresetn(aresetn), .rom_req(rom_req),
    .rom_addr(rom_addr), .rom_data(rom_data), .rom_ack(rom_ack), .us_evt(us_evt), .sec_serr_o(sec_serr_o),
    .sec_serr_oe_n(sec_serr_oe_n), .cfg_retry(cfg_retry), .cfg_out(cfg_out));

// ===== tb/cfg_preload_tb.sv
`timescale 1ns/10ps
module cfg_preload_tb;
    logic              aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
    logic [11:0]       awaddr = '0, araddr = '0;
    logic [31:0]       wdata = '0, rdata, rd_v;
    logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic              awready, wready, bvalid, arready, rvalid, rom_req, rom_ack, oe_n, serr, retry;
    logic [1:0]        bresp, rresp;
    logic [7:0]        rom_addr, rom_data, hdr = 8'h80;
    logic [6:0]        evt = '0;
    preload_pkg::cfg_t cfg;
    preload_pkg::pm_t  pm, pm_e;
    int                error_cnt = 0, check_count = 0;
    always #50 aclk = ~aclk;
    cfg_preload cfg_preload_i (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
        .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready),
        .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
        .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
        .rom_req(rom_req), .rom_addr(rom_addr), .rom_data(rom_data), .rom_ack(rom_ack), .us_evt(evt),
        .sec_serr_o(serr), .sec_serr_oe_n(oe_n), .cfg_retry(retry), .cfg_out(cfg), .pm_out(pm));
    rom_model rom_model_i (.aclk(aclk), .rom_req(rom_req), .rom_addr(rom_addr), .hdr(hdr), .slow(slow),
        .rom_data(rom_data), .rom_ack(rom_ack));
    task automatic results;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) bready <= 1'b0;
        end while (bvalid !== 1'b1);
        chk("bresp", 32'h0, 32'(bresp));
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        chk("rresp", 32'h0, 32'(rresp));
        rready <= 1'b0;
    endtask : rd
    task automatic restart(input logic [7:0] h);
        {hdr, aresetn} <= {h, 1'b0};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int n = 0; n < 400 && retry !== 1'b0; n++) @(posedge aclk);
        chk("retry", 32'h0, 32'(retry));
    endtask : restart
    task automatic pulse(input int b, input logic e);
        @(posedge aclk);
        evt <= 7'(1 << b);
        @(posedge aclk);
        evt <= 7'h00;
        @(posedge aclk);
        chk("oe_n", 32'(e), 32'(oe_n));
    endtask : pulse
    task automatic t_abort;
        logic [7:0] h [3] = '{8'h00, 8'h40, 8'hc0};
        for (int i = 0; i < 3; i++) begin
            restart(h[i]);
            chk("cfg_reset", 32'h0, 32'(cfg !== preload_pkg::CFG_RESET));
            rd(12'h354, rd_v);
            chk("mask_reset", 32'h0, rd_v);
            rd(12'h35c, rd_v);
            chk("status", 32'h2, rd_v);
        end
    endtask : t_abort
    task automatic t_load;
        logic [15:0] w;
        slow <= 1'b1;
        restart(8'h80);
        for (int i = 0; i < 63; i++)
            chk("cfg_byte", 32'(8'(i + 4) ^ 8'ha6), 32'(cfg[8*i +: 8]));
        w = {8'h42 ^ 8'ha6, 8'h41 ^ 8'ha6};
        pm_e = '{{1'b0, w[15:10], 3'b0, w[9], 2'b0, w[8:6]}, {1'b0, w[5:4], 13'b0}, w[3], {w[2], 7'b0}};
        chk("pm", 32'h0, 32'(pm !== pm_e));
        rd(12'h354, rd_v);
        chk("mask_load", 32'((8'h37 ^ 8'ha6) & 8'h7f), rd_v);
        rd(12'h35c, rd_v);
        chk("status", 32'h5, rd_v);
        slow <= 1'b0;
    endtask : t_load
    task automatic t_mask;
        wr(12'h354, 32'hffffffff);
        rd(12'h354, rd_v);
        chk("mask_rw", 32'h7f, rd_v);
        wr(12'h400, 32'hffffffff);
        rd(12'h400, rd_v);
        chk("unmapped", 32'h0, rd_v);
        for (int b = 0; b < 7; b++) begin
            wr(12'h354, 32'h1 << b);
            pulse(b, 1'b1);
            wr(12'h354, 32'h7f ^ (32'h1 << b));
            pulse(b, 1'b0);
            rd(12'h358, rd_v);
            chk("flag_set", 32'h1 << b, rd_v);
            wr(12'h358, 32'h1 << b);
            rd(12'h358, rd_v);
            chk("flag_clr", 32'h0, rd_v);
        end
    endtask : t_mask
    initial begin
        #2000000;
        error_cnt++;
        results();
    end
    initial begin
        t_abort();
        t_load();
        t_mask();
        results();
    end
endmodule : cfg_preload_tb

// ===== tb/rom_model.sv
`timescale 1ns/10ps
module rom_model (
    input  wire logic       aclk,     // Bridge clock
    input  wire logic       rom_req,  // Byte request
    input  wire logic [7:0] rom_addr, // Byte address
    input  wire logic [7:0] hdr,      // Byte 00h value
    input  wire logic       slow,     // Ack every other cycle
    output logic      [7:0] rom_data, // Byte out
    output logic            rom_ack   // Byte valid
);
    logic [7:0] img;
    always_comb begin
        img = rom_addr ^ 8'ha6;
        if (rom_addr == 8'h00) img = hdr;
        else if (rom_addr < 8'h04) img = 8'h00;
    end
    // Line carries the inverted byte while no byte is offered
    assign rom_data = rom_ack ? img : ~img;
    initial rom_ack = 1'b0;
    always @(posedge aclk) rom_ack <= rom_req && !(slow && rom_ack);
endmodule : rom_model
